/* src/sysif_codec_defs.vh */
// Constants for the system interface command/identifier codec.
// Assumes a single system bus clock; included by bare name from design files.
// How it works
// - External request seen two cycles after assertion
// - Release to slave after current cycle group
// - Take writes at once, error every read
// - Bit 8 low command, high identifier
// - Bits 7:5 read 0, write 2, null 3
// - Read bits 4:3 block 2, word 3
// - Block read size 0 two, 1 eight words
// - Partial read bits 1:0 valid bytes minus one
// - Write bits 4:3 block 2, word 3
// - Block write size, bit 2 retain line
// - Partial write bits 1:0 valid bytes minus one
// - Null with bits 4:3 zero releases interface
// - Id bit 7 last low, bit 6 response low
// - Id bit 5 error; incoming error forces bus error
// - Agent id bit 4 high skips checking
// - Own reserved bits undefined, never relied upon
// - Full 32-bit address on address cycles
// - Addresses aligned to access size; 8-word block reads to doubleword
// - Block write starts at block base, ascending
// - Byte lanes follow position in word
// - Lane table per size, endian mirrored
// - External read answered with error identifier
// - Low word first little endian, high big
`ifndef SYSIF_CODEC_DEFS_VH
`define SYSIF_CODEC_DEFS_VH
`define CMD_W 9
`define CMD_IS_ID 8
`define CMD_TYPE_HI 7
`define CMD_TYPE_LO 5
`define TYPE_READ 3'h0
`define TYPE_WRITE 3'h2
`define TYPE_NULL 3'h3
`define ATTR_BLOCK 2'h2
`define ATTR_WORD 2'h3
`define ATTR_RELEASE 2'h0
`define BSIZE_2W 2'h0
`define BSIZE_8W 2'h1
`define ID_LAST_N 7
`define ID_RESP_N 6
`define ID_ERR 5
`define ID_NOCHK 4
`define REQ_DETECT_CYC 2
`define ST_MASTER 2'h0
`define ST_SLAVE 2'h1
`define ST_RDRESP 2'h2
`endif

/* src/sysif_lane_map.v */
// Byte-lane enables for a partial-word transfer within one 32-bit lane group.
// Assumes inputs from the same clock domain; pure combinational.
`timescale 1ns/1ps
module sysif_lane_map (
  input wire [1:0] sizeCode, // Valid bytes minus one
  input wire [1:0] addrLow, // Address modulo 4
  input wire bigEndian, // High for big-endian lane order
  output reg [3:0] laneEn // Lane 0 is bits 7:0
);
  reg [3:0] leMask;
  always @*
  begin
    case (sizeCode)
      2'h0: leMask = 4'h1 << addrLow;
      2'h1: leMask = addrLow[1] ? 4'hC : 4'h3;
      2'h2: leMask = addrLow[0] ? 4'hE : 4'h7;
      default: leMask = 4'hF;
    endcase
    // Big-endian mirrors the little-endian lanes
    laneEn = bigEndian ? {leMask[0], leMask[1], leMask[2], leMask[3]} : leMask;
  end
endmodule

/* src/sysif_codec.v */
// Device end of the system interface: issues read/write requests, takes
// external writes and read responses, answers external reads with errors.
// Assumes the agent drives the shared lines only while this end is slave.
`timescale 1ns/1ps
`include "sysif_codec_defs.vh"
module sysif_codec #(
  parameter ADDR_W = 32, // Address/data bus width
  parameter DETECT_CYC = `REQ_DETECT_CYC // Cycles until external request seen
) (
  input wire core_clk, // System bus clock
  input wire nrst, // Synchronous reset, active low
  input wire reqStart, // Pulse: start a processor request
  input wire reqWrite, // High for write, low for read
  input wire reqBlock, // High for block transfer
  input wire reqEight, // Block of 8 words instead of 2
  input wire reqRetain, // Keep cache line on 8-word write
  input wire [1:0] reqSize, // Partial: valid bytes minus one
  input wire [31:0] reqAddr, // Request address
  input wire [63:0] wrData, // Next doubleword to write
  input wire bigEndian, // Big-endian word order and lanes
  input wire agentReq_n, // External request, active low pin
  input wire agent_valid_n, // Agent cycle valid, active low pin
  input wire [8:0] cmdIn, // command_id_bus input
  input wire [31:0] adIn, // addr_data_bus input
  output reg [8:0] cmdOut_r, // command_id_bus output
  output reg [8:0] cmdOe_r, // High while this end drives command bus
  output reg [31:0] adOut_r, // addr_data_bus output
  output reg [31:0] adOe_r, // High while this end drives data bus
  output reg busy_r, // Processor request in progress
  output reg wrDataTake_r, // Pulse: wrData doubleword consumed
  output reg slave_r, // Interface released to agent
  output reg rdValid_r, // Pulse: read response word captured
  output reg [31:0] rdWord_r, // Captured response word
  output reg [3:0] rdLanes_r, // Valid byte lanes of rdWord_r
  output reg rdLast_r, // Response word was the last one
  output reg busError_r, // Pulse: erroneous response data
  output reg checkSkip_r, // Agent asked to skip checking
  output reg extWrValid_r, // Pulse: external write taken
  output reg [31:0] extWrAddr_r, // Address of external write
  output reg [31:0] extWrData_r // Data of external write
);
  localparam CNT_W = 4;
  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [DETECT_CYC-1:0] ereqSync;
  reg validMeta, validSync;
  reg [8:0] cmdMeta, cmdSync;
  reg [31:0] adMeta, adSync;
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ereqSync <= {DETECT_CYC{1'b1}};
      validMeta <= 1'b1;
      validSync <= 1'b1;
      cmdMeta <= 9'h000;
      cmdSync <= 9'h000;
      adMeta <= 32'h0000_0000;
      adSync <= 32'h0000_0000;
    end
    else
    begin
      // Request counts as detected after this many flops
      ereqSync <= {ereqSync[DETECT_CYC-2:0], agentReq_n};
      validMeta <= agent_valid_n;
      validSync <= validMeta;
      cmdMeta <= cmdIn;
      cmdSync <= cmdMeta;
      adMeta <= adIn;
      adSync <= adMeta;
    end
  end
  wire extReq = ~ereqSync[DETECT_CYC-1];
  wire inValid = ~validSync;
  wire isId = cmdSync[`CMD_IS_ID];
  wire [2:0] inType = cmdSync[`CMD_TYPE_HI:`CMD_TYPE_LO];
  wire [1:0] inAttr = cmdSync[4:3];
  ////////////////////////////////////////////////////////////////
  // Lane decode for partial transfers
  wire [3:0] laneEn;
  reg curWrite, curBlock;
  reg [1:0] curSize;
  reg [31:0] curAddr;
  sysif_lane_map u_lanes (
    .sizeCode(curSize),
    .addrLow(curAddr[1:0]),
    .bigEndian(bigEndian),
    .laneEn(laneEn)
  );
  ////////////////////////////////////////////////////////////////
  // Request sequencing
  reg [1:0] state_r, state_nxt;
  reg [CNT_W-1:0] cnt_r, cnt_nxt;
  reg [CNT_W-1:0] words_r, words_nxt;
  reg [63:0] dwHold;
  reg rdPend;
  reg extRdErr; // External read owes an error identifier
  reg [31:0] alignAddr;
  always @*
  begin
    // Block to 8 bytes, full word to 4, halfword to 2, others unchanged
    if (reqBlock)
      alignAddr = {reqAddr[31:3], 3'h0};
    else if (reqSize == 2'h3)
      alignAddr = {reqAddr[31:2], 2'h0};
    else if (reqSize == 2'h1)
      alignAddr = {reqAddr[31:1], 1'b0};
    else
      alignAddr = reqAddr;
  end
  wire [8:0] newCmd = {1'b0, reqWrite ? `TYPE_WRITE : `TYPE_READ,
    reqBlock ? `ATTR_BLOCK : `ATTR_WORD,
    reqBlock & reqWrite & reqEight & reqRetain,
    reqBlock ? (reqEight ? `BSIZE_8W : `BSIZE_2W) : reqSize};
  // Write blocks start at the block base; reads at the addressed doubleword
  wire [31:0] blockBase = reqEight ? {reqAddr[31:5], 5'h00} : {reqAddr[31:3], 3'h0};
  wire [31:0] issueAddr = (reqBlock & reqWrite) ? blockBase : alignAddr;
  // First word of a doubleword: low in little endian, high in big
  wire firstHalf = ~cnt_r[0];
  wire [31:0] dwWord = (firstHalf ^ bigEndian) ? dwHold[31:0] : dwHold[63:32];
  wire lastWr = (cnt_r == words_r - 4'h1);
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    words_nxt = words_r;
    case (state_r)
      `ST_MASTER:
      begin
        // Release here only between requests; a pending read releases from ST_RDRESP
        if (extReq && !busy_r)
          state_nxt = `ST_SLAVE;
        else if (busy_r && curWrite && lastWr)
          cnt_nxt = 4'h0;
        else if (busy_r && curWrite)
          cnt_nxt = cnt_r + 4'h1;
        else if (busy_r && !curWrite)
          state_nxt = `ST_RDRESP;
      end
      `ST_SLAVE:
      begin
        if (inValid && !isId && inType == `TYPE_NULL && inAttr == `ATTR_RELEASE)
          state_nxt = rdPend ? `ST_RDRESP : `ST_MASTER;
      end
      `ST_RDRESP:
      begin
        if (extReq)
          state_nxt = `ST_SLAVE;
        else if (inValid && isId && !cmdSync[`ID_LAST_N])
          state_nxt = `ST_MASTER;
      end
      default: state_nxt = `ST_MASTER;
    endcase
  end
  ////////////////////////////////////////////////////////////////
  // Registered outputs and datapath
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_r <= `ST_MASTER;
      cnt_r <= 4'h0;
      words_r <= 4'h0;
      curWrite <= 1'b0;
      curBlock <= 1'b0;
      curSize <= 2'h0;
      curAddr <= 32'h0000_0000;
      dwHold <= 64'h0000_0000_0000_0000;
      rdPend <= 1'b0;
      extRdErr <= 1'b0;
      cmdOut_r <= 9'h000;
      cmdOe_r <= 9'h000;
      adOut_r <= 32'h0000_0000;
      adOe_r <= 32'h0000_0000;
      busy_r <= 1'b0;
      wrDataTake_r <= 1'b0;
      slave_r <= 1'b0;
      rdValid_r <= 1'b0;
      rdWord_r <= 32'h0000_0000;
      rdLanes_r <= 4'h0;
      rdLast_r <= 1'b0;
      busError_r <= 1'b0;
      checkSkip_r <= 1'b0;
      extWrValid_r <= 1'b0;
      extWrAddr_r <= 32'h0000_0000;
      extWrData_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      words_r <= words_nxt;
      slave_r <= (state_nxt == `ST_SLAVE);
      wrDataTake_r <= 1'b0;
      rdValid_r <= 1'b0;
      busError_r <= 1'b0;
      extWrValid_r <= 1'b0;
      cmdOe_r <= 9'h000;
      adOe_r <= 32'h0000_0000;
      if (state_r == `ST_MASTER && state_nxt == `ST_MASTER && extRdErr)
      begin
        // Error identifier for an external read, data undefined
        cmdOut_r <= {1'b1, 1'b0, 1'b0, 1'b1, 5'h00};
        cmdOe_r <= 9'h1FF;
        adOut_r <= 32'h0000_0000;
        adOe_r <= 32'hFFFF_FFFF;
        extRdErr <= 1'b0;
      end
      else if (state_r == `ST_MASTER && state_nxt == `ST_MASTER && !busy_r && reqStart)
      begin
        // Address cycle: full address; reserved fields left zero
        busy_r <= 1'b1;
        curWrite <= reqWrite;
        curBlock <= reqBlock;
        curSize <= reqSize;
        curAddr <= issueAddr;
        cmdOut_r <= newCmd;
        cmdOe_r <= 9'h1FF;
        adOut_r <= issueAddr;
        adOe_r <= 32'hFFFF_FFFF;
        cnt_r <= 4'h0;
        words_r <= reqBlock ? (reqEight ? 4'h8 : 4'h2) : 4'h1;
        dwHold <= wrData;
        wrDataTake_r <= reqWrite;
        rdPend <= ~reqWrite;
      end
      else if (state_r == `ST_MASTER && busy_r && curWrite && state_nxt == `ST_MASTER)
      begin
        // Data cycles run ascending from block start
        cmdOut_r <= {1'b1, ~lastWr, 1'b1, 1'b0, 5'h00};
        cmdOe_r <= 9'h1FF;
        adOut_r <= curBlock ? dwWord : dwHold[31:0];
        adOe_r <= 32'hFFFF_FFFF;
        if (curBlock && cnt_r[0] && !lastWr)
        begin
          dwHold <= wrData;
          wrDataTake_r <= 1'b1;
        end
        if (lastWr)
          busy_r <= 1'b0;
      end
      if (state_r == `ST_RDRESP && inValid && isId)
      begin
        // Response words; reserved ids ignored
        rdValid_r <= 1'b1;
        rdWord_r <= adSync;
        rdLanes_r <= curBlock ? 4'hF : laneEn;
        rdLast_r <= ~cmdSync[`ID_LAST_N];
        busError_r <= cmdSync[`ID_ERR];
        checkSkip_r <= cmdSync[`ID_NOCHK];
        if (!cmdSync[`ID_LAST_N])
        begin
          busy_r <= 1'b0;
          rdPend <= 1'b0;
        end
      end
      if (state_r == `ST_SLAVE && inValid && !isId && inType == `TYPE_WRITE)
      begin
        extWrAddr_r <= adSync;
      end
      if (state_r == `ST_SLAVE && inValid && isId && cmdSync[`ID_RESP_N])
      begin
        // External write data is taken at once
        extWrValid_r <= 1'b1;
        extWrData_r <= adSync;
        checkSkip_r <= cmdSync[`ID_NOCHK];
        busError_r <= cmdSync[`ID_ERR];
      end
      if (state_r == `ST_SLAVE && inValid && !isId && inType == `TYPE_READ)
        extRdErr <= 1'b1;
    end
  end
endmodule

/* tb/sysif_codec_sva.sv */
// Pin checker for the codec: command codes, identifiers, release and error timing.
// Bound to sysif_codec; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module sysif_codec_sva (
  input wire core_clk, // Clock
  input wire nrst, // Reset
  input wire reqStart, // Start pulse
  input wire reqBlock, // Block request
  input wire [31:0] reqAddr, // Request address
  input wire busy_r, // Busy
  input wire slave_r, // Released
  input wire agentReq_n, // External request
  input wire agent_valid_n, // Agent valid
  input wire [8:0] cmdIn, // Agent command
  input wire [8:0] cmdOut_r, // Own command
  input wire [8:0] cmdOe_r, // Command enable
  input wire [31:0] adOut_r, // Own address/data
  input wire busError_r // Error pulse
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  wire cmdCyc = cmdOe_r[8] && !cmdOut_r[8];
  wire agentCmd = slave_r && !agent_valid_n;
  // The error answer can only go out once the bus is back with the codec
  reg rdOwed_r;
  always @(posedge core_clk)
  begin
    if (!nrst)
      rdOwed_r <= 1'b0;
    else if (agentCmd && cmdIn[8:5] == 4'h0)
      rdOwed_r <= 1'b1;
    else if (cmdOe_r[8] && cmdOut_r == 9'h120)
      rdOwed_r <= 1'b0;
  end
  ////////////////////////////////////////
  AST_CMD_CODE: assert property (cmdCyc |-> (cmdOut_r[7:5] == 3'h0 || cmdOut_r[7:5] == 3'h2) && cmdOut_r[4])
    else $error("bad command code");
  AST_BLK_ALIGN: assert property (cmdCyc && cmdOut_r[4:3] == 2'h2 |-> adOut_r[2:0] == 3'h0 && !cmdOut_r[1])
    else $error("bad block command");
  AST_WORD_ADDR: assert property (reqStart && !busy_r && !slave_r && !reqBlock |=>
    cmdCyc && adOut_r == $past(reqAddr)) else $error("bad address cycle");
  AST_WORD_ID: assert property (cmdCyc && cmdOut_r[7:3] == 5'h0b |=> cmdOe_r[8] && cmdOut_r[8:6] == 3'h5)
    else $error("bad write identifier");
  AST_BLK8_IDS: assert property (cmdCyc && cmdOut_r[7:3] == 5'h0a && cmdOut_r[1:0] == 2'h1 |=>
    (cmdOut_r[8:7] == 2'h3)[*7] ##1 cmdOut_r[8:6] == 3'h5) else $error("bad block identifiers");
  AST_DETECT: assert property ($fell(agentReq_n) && !slave_r && !busy_r |-> !slave_r[*2] ##[1:40] slave_r)
    else $error("bad release timing");
  AST_EXT_RD: assert property ($fell(slave_r) && rdOwed_r |-> ##[1:4] cmdOe_r[8] && cmdOut_r == 9'h120)
    else $error("missing read error answer");
  AST_RELEASE: assert property (agentCmd && cmdIn == 9'h060 |-> ##[1:6] !slave_r)
    else $error("release ignored");
  AST_BUSERR: assert property (busy_r && !agent_valid_n && cmdIn[8] && !cmdIn[6] && cmdIn[5] |-> ##[1:6] busError_r)
    else $error("missing bus error");
endmodule
bind sysif_codec sysif_codec_sva u_sysif_codec_sva (.core_clk, .nrst, .reqStart, .reqBlock, .reqAddr, .busy_r,
  .slave_r, .agentReq_n, .agent_valid_n, .cmdIn, .cmdOut_r, .cmdOe_r, .adOut_r, .busError_r);

/* tb/agent_model.sv */
// External agent model: drives the agent pins and records the first 64 codec bus cycles.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
module agent_model (
  input wire core_clk, // Clock
  input wire [8:0] cmdOut_r, // Codec command
  input wire [8:0] cmdOe_r, // Codec enable
  input wire [31:0] adOut_r, // Codec address/data
  output reg agentReq_n = 1'b1, // External request
  output reg agent_valid_n = 1'b1, // Agent valid
  output reg [8:0] cmdIn = 9'h000, // Agent command
  output reg [31:0] adIn = 32'h0000_0000 // Agent address/data
);
  reg [40:0] cap [0:63];
  integer nCap = 0;
  ////////////////////////////////////////
  always @(posedge core_clk)
  begin
    if (cmdOe_r[8] && nCap < 64)
    begin
      cap[nCap] <= {cmdOut_r, adOut_r};
      nCap <= nCap + 1;
    end
  end
  task setReq(input v);
  begin
    @(posedge core_clk);
    agentReq_n <= v;
  end
  endtask
  // Released lines show the inverse so a stale value never passes
  task drive(input [8:0] c, input [31:0] a);
  begin
    @(posedge core_clk);
    agent_valid_n <= 1'b0;
    cmdIn <= c;
    adIn <= a;
    @(posedge core_clk);
    agent_valid_n <= 1'b1;
    cmdIn <= ~c;
    adIn <= ~a;
  end
  endtask
  task respond(input integer n, input integer errAt, input [31:0] d);
    integer k;
  begin
    for (k = 0; k < n; k = k + 1)
      drive({1'b1, k != n - 1, 1'b0, k == errAt, 5'h00}, d + k);
  end
  endtask
endmodule

/* tb/tb_sysif_codec.sv */
// Bench for the codec: table of word requests, then block, external and reset cases.
// Inputs change at rising edges; the agent model drives the agent pins.
`timescale 1ns/1ps
module tb_sysif_codec;
  reg core_clk = 1'b0;
  reg nrst = 1'b0;
  reg reqStart = 1'b0, reqWrite = 1'b0, reqBlock = 1'b0, reqEight = 1'b0, reqRetain = 1'b0, bigEndian = 1'b0;
  reg [1:0] reqSize = 2'h0;
  reg [31:0] reqAddr = 32'h0000_0000;
  reg [63:0] wrData = 64'h89ab_cdef_0123_4567;
  wire agentReq_n, agent_valid_n, busy_r, wrDataTake_r, slave_r, rdValid_r, rdLast_r, busError_r;
  wire checkSkip_r, extWrValid_r;
  wire [8:0] cmdIn, cmdOut_r, cmdOe_r;
  wire [31:0] adIn, adOut_r, adOe_r, rdWord_r, extWrAddr_r, extWrData_r;
  wire [3:0] rdLanes_r;
  reg [31:0] lastWord;
  reg [9:0] rows [0:6];
  integer errors = 0, checked = 0, cycles = 0, nRd = 0, nErr = 0, nWr = 0, base, i, j, n;
  sysif_codec u_sysif_codec (.core_clk, .nrst, .reqStart, .reqWrite, .reqBlock, .reqEight, .reqRetain, .reqSize,
    .reqAddr, .wrData, .bigEndian, .agentReq_n, .agent_valid_n, .cmdIn, .adIn, .cmdOut_r, .cmdOe_r, .adOut_r,
    .adOe_r, .busy_r, .wrDataTake_r, .slave_r, .rdValid_r, .rdWord_r, .rdLanes_r, .rdLast_r, .busError_r,
    .checkSkip_r, .extWrValid_r, .extWrAddr_r, .extWrData_r);
  agent_model u_agent_model (.core_clk, .cmdOut_r, .cmdOe_r, .adOut_r, .agentReq_n, .agent_valid_n, .cmdIn, .adIn);
  ////////////////////////////////////////
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (rdValid_r === 1'b1)
      {nRd, lastWord} = {nRd + 1, rdWord_r};
    if (busError_r === 1'b1)
      nErr = nErr + 1;
    if (extWrValid_r === 1'b1)
      nWr = nWr + 1;
    // A fresh doubleword after each take shows the ascending order
    if (wrDataTake_r === 1'b1)
      wrData <= wrData + 64'h0000_0001_0000_0001;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      give_verdict;
    end
  end
  task check(input [79:0] seen, input [79:0] exp, input [8*10-1:0] what);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("unexpected %0s: expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task give_verdict;
  begin
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task start(input w, input b, input e, input [1:0] s, input [31:0] a, input big);
  begin
    @(posedge core_clk);
    {reqStart, reqWrite, reqBlock, reqEight, reqRetain, reqSize, reqAddr, bigEndian} <= {3'h4 | {w, b}, e, e, s, a, big};
    @(posedge core_clk);
    reqStart <= 1'b0;
    base = u_agent_model.nCap;
  end
  endtask
  // Bounded wait so a stuck handshake counts an error instead of hanging the run
  task waitSig(input sel, input val);
    integer k;
  begin
    k = 0;
    @(posedge core_clk);
    while ((sel ? slave_r : busy_r) !== val && k < 200)
    begin
      @(posedge core_clk);
      k = k + 1;
    end
    check(k < 200, 1'b1, "wait");
    repeat (3) @(posedge core_clk);
  end
  endtask
  initial
  begin
    rows[0] = {1'b0, 2'h0, 2'h1, 1'b0, 4'h2};
    rows[1] = {1'b0, 2'h1, 2'h2, 1'b1, 4'h3};
    rows[2] = {1'b0, 2'h2, 2'h1, 1'b0, 4'he};
    rows[3] = {1'b0, 2'h2, 2'h0, 1'b1, 4'he};
    rows[4] = {1'b0, 2'h3, 2'h0, 1'b1, 4'hf};
    rows[5] = {1'b1, 2'h0, 2'h3, 1'b1, 4'h0};
    rows[6] = {1'b1, 2'h3, 2'h0, 1'b0, 4'h0};
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    check({cmdOe_r, adOe_r, busy_r, slave_r}, 43'h0, "reset");
    for (i = 0; i < 7; i = i + 1)
    begin
      start(rows[i][9], 1'b0, 1'b0, rows[i][8:7], 32'h1000_0000 + rows[i][6:5], rows[i][4]);
      if (!rows[i][9])
      begin
        repeat (2) @(posedge core_clk);
        u_agent_model.respond(1, 9, 32'h5a5a_0000 + i);
      end
      waitSig(1'b0, 1'b0);
      check(u_agent_model.cap[base], {1'b0, rows[i][9] ? 3'h2 : 3'h0, 3'h6, rows[i][8:7],
        32'h1000_0000 + rows[i][6:5]}, "command");
      if (rows[i][9])
        check(u_agent_model.cap[base + 1][40:32], 9'h140, "write id");
      else
        check({lastWord, rdLanes_r}, {32'h5a5a_0000 + i, rows[i][3:0]}, "read word");
      $display("row %0d done", i);
    end
    for (j = 0; j < 2; j = j + 1)
    begin
      n = j ? 2 : 8;
      wrData <= 64'h89ab_cdef_0123_4567;
      start(1'b1, 1'b1, !j[0], 2'h0, 32'h1000_0018, j[0]);
      waitSig(1'b0, 1'b0);
      check(u_agent_model.cap[base], {j ? 9'h050 : 9'h055, j ? 32'h1000_0018 : 32'h1000_0000}, "block cmd");
      for (i = 1; i <= n; i = i + 1)
        check(u_agent_model.cap[base + i], {n == i ? 9'h140 : 9'h1c0,
          (i[0] ^ j[0] ? 32'h0123_4567 : 32'h89ab_cdef) + (i - 1) / 2}, "dword");
      $display("block write %0d done", j);
    end
    start(1'b0, 1'b1, 1'b0, 2'h0, 32'h2000_000c, 1'b0);
    repeat (2) @(posedge core_clk);
    {j, n} = {nRd, nErr};
    u_agent_model.respond(2, 0, 32'h7700_0000);
    waitSig(1'b0, 1'b0);
    check(u_agent_model.cap[base], {9'h010, 32'h2000_0008}, "block read");
    check({nRd - j, nErr - n > 0, lastWord, rdLast_r}, {32'h2, 1'b1, 32'h7700_0001, 1'b1}, "response");
    $display("block read done");
    u_agent_model.setReq(1'b0);
    waitSig(1'b1, 1'b1);
    start(1'b1, 1'b0, 1'b0, 2'h3, 32'h3000_0000, 1'b0);
    repeat (4) @(posedge core_clk);
    check(u_agent_model.nCap - base, 32'h0, "refused");
    u_agent_model.drive(9'h05b, 32'h0000_0008);
    u_agent_model.drive(9'h150, 32'hcafe_0001);
    repeat (4) @(posedge core_clk);
    check({extWrAddr_r, extWrData_r, checkSkip_r, nWr[3:0]}, {32'h8, 32'hcafe_0001, 1'b1, 4'h1}, "ext write");
    base = u_agent_model.nCap;
    u_agent_model.drive(9'h01b, 32'h0000_0000);
    repeat (8) @(posedge core_clk);
    // The error answer waits until the agent hands the bus back
    u_agent_model.setReq(1'b1);
    u_agent_model.drive(9'h060, 32'h0000_0000);
    waitSig(1'b1, 1'b0);
    check(u_agent_model.cap[base][40:32], 9'h120, "ext read");
    $display("external done");
    start(1'b1, 1'b1, 1'b1, 2'h0, 32'h1000_0000, 1'b0);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    check({cmdOe_r, adOe_r, busy_r, slave_r}, 43'h0, "mid reset");
    $display("reset done");
    give_verdict;
  end
endmodule
